// [rtl/sdcd_beat_if.sv]
// Purpose: beat stream between burst sequencer and buffer
// Assumes: one beat per cycle
// Notes: valid and ready handshake
interface sdcd_beat_if;
    import sdcd_pkg::*;
    logic              valid;
    logic              ready;
    logic [FIFO_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [rtl/sdcd_fifo.sv]
// Purpose: beat buffer with valid and ready on both sides
// Assumes: depth a power of two
// Notes: read data comes from a register
module sdcd_fifo
    import sdcd_pkg::*;
#(
    parameter int W = FIFO_W,
    parameter int D = FIFO_D
)
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    // fill side
    sdcd_beat_if.snk  s_in,
    // drain side
    output logic [W-1:0] o_data,
    output logic         o_valid,
    input  wire logic    i_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed
    {
        logic [AW:0]   wp;
        logic [AW:0]   rp;
        logic [W-1:0]  q;
        logic          qv;
    } sdcd_fifo_s;
    sdcd_fifo_s st_ff;
    sdcd_fifo_s nxt_st;
    logic [W-1:0] mem [D];
    logic full;
    logic empty;
    logic take;
    logic push;
    assign full  = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
    assign empty = st_ff.wp == st_ff.rp;
    assign s_in.ready = !full;
    assign push = s_in.valid && !full;
    assign take = !empty && (!st_ff.qv || i_ready);
    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (st_ff.qv && i_ready)
        begin
            nxt_st.qv = 1'b0;
        end
        if (take)
        begin
            nxt_st.q  = mem[st_ff.rp[AW-1:0]];
            nxt_st.qv = 1'b1;
            nxt_st.rp = st_ff.rp + 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
        if (push)
        begin
            mem[st_ff.wp[AW-1:0]] <= s_in.data;
        end
    end
    assign o_data  = st_ff.q;
    assign o_valid = st_ff.qv;
endmodule

// [rtl/sdcd_pkg.sv]
// Purpose: shared constants and types of the command and clock-enable decoder
// Assumes: x8 organisation, 16 row bits, 10 column bits, 8 banks
// Notes: delay counts are cycle figures configured for the chosen speed grade
//
// Function
// R1: commands decoded from select, row, column, write strobes and clock enable each edge
// R2: reset pin is held high by the controller; low acts only as reset
// R3: all four strobes low with enable high loads mode register chosen by bank
// R4: bank address selects bank; activate opens row; precharge one or all by A10
// R5: read and write decoded; A10 asks auto precharge; column gives start
// R6: on-the-fly length uses A12 low as chop, high as eight beats
// R7: three low column bits give first read beat index
// R8: sequential eight-beat read wraps in its group of four then other group
// R9: interleaved eight-beat read index is beat count xor start
// R10: chopped read sends four beats then floats data and strobe four slots
// R11: writes ignore low two bits; chop picks half; eight beats run in order
// R12: started bursts run to completion; length choice from mode register
// R13: nop and deselect are no operation and never end an operation
// R14: power transitions judged from previous and current enable samples
// R15: controller keeps enable stable for the minimum count after a change
// R16: power-down on enable fall, exit on rise, only with nop; no refresh
// R17: power-down is precharge type if all banks closed, else active type
// R18: controller enters self refresh only from all banks idle
// R19: all banks idle means closed, enable high and timings expired
// R20: controller issues only nop during exit delay, reads after longer delay
// R21: self-refresh exit is asynchronous; termination off in self refresh; the code exits only on an enable high sampled at the rising clock
// R22: controller lowers enable only after mode register delays
// R23: controller issues no unlisted state and command combination
// R24: length field picks fixed chop, fixed eight, or per-command selection
// R25: delays held as cycle parameters for the speed grade
package sdcd_pkg;
    localparam int ROW_W   = 16;
    localparam int BANK_N  = 8;
    localparam int FIFO_W  = 16;
    localparam int FIFO_D  = 8;
    localparam int MR_W    = 16;
    // mode register 0 field positions
    localparam int MR0_BL_LSB = 0;
    localparam int MR0_BT_BIT = 3;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [15:0] MR_RESET = 16'h0000;
    // address bit positions
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    // delays in clock cycles
    localparam logic [7:0] CKE_MIN_CYC = 8'h03;
    localparam logic [7:0] XS_CYC      = 8'h10;
    localparam logic [7:0] XSDLL_CYC   = 8'h40;

    typedef enum logic [3:0]
    {
        CMD_DES  = 4'h0,
        CMD_NOP  = 4'h1,
        CMD_MRS  = 4'h2,
        CMD_REF  = 4'h3,
        CMD_PRE  = 4'h4,
        CMD_ACT  = 4'h5,
        CMD_RD   = 4'h6,
        CMD_WR   = 4'h7,
        CMD_ZQ   = 4'h8,
        CMD_ILL  = 4'h9
    } sdcd_cmd_e;

    typedef enum logic [2:0]
    {
        PS_IDLE = 3'h0,
        PS_APD  = 3'h1,
        PS_PPD  = 3'h2,
        PS_SREF = 3'h3,
        PS_XSR  = 3'h4
    } sdcd_pstate_e;
endpackage

// [rtl/sdcd_top.sv]
// Purpose: command decode, burst ordering and clock-enable power state
// Assumes: pins sampled synchronously on the rising clock
// Notes: reset pin is active low and treated as a synchronous reset here
module sdcd_top
    import sdcd_pkg::*;
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    // command pins
    input  wire logic              i_reset_n,
    input  wire logic              i_cke,
    input  wire logic              i_cs_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic [2:0]        i_ba,
    input  wire logic [ROW_W-1:0]  i_addr,
    // beat stream out
    input  wire logic              i_beat_ready,
    output logic [FIFO_W-1:0]      o_beat,
    output logic                   o_beat_valid,
    // decoded command
    output logic [3:0]             o_cmd,
    output logic                   o_cmd_pulse,
    output logic [2:0]             o_cmd_bank,
    output logic [ROW_W-1:0]       o_cmd_addr,
    output logic                   o_auto_pre,
    output logic                   o_chop,
    // state
    output logic [BANK_N-1:0]      o_bank_open,
    output logic [2:0]             o_pstate,
    output logic                   o_odt_allowed,
    output logic                   o_read_ok,
    output logic                   o_busy,
    output logic                   o_dq_oe,
    output logic [MR_W-1:0]        o_mr0
);
    typedef struct packed
    {
        logic                  cke_prev;
        logic [3:0]            cmd;
        logic                  pulse;
        logic [2:0]            bank;
        logic [ROW_W-1:0]      addr;
        logic                  ap;
        logic                  chop;
        logic [BANK_N-1:0]     open;
        logic [MR_W-1:0]       mr0;
        logic [MR_W-1:0]       mr1;
        logic [MR_W-1:0]       mr2;
        logic [MR_W-1:0]       mr3;
        logic [2:0]            ps;
        logic [7:0]            xcnt;
        logic                  rd_ok;
        logic                  bact;
        logic                  brd;
        logic                  bchop;
        logic                  bseq;
        logic [2:0]            bstart;
        logic [2:0]            bcnt;
        logic [2:0]            bbank;
        logic                  bap;
        logic                  oe;
        logic                  odt;
    } sdcd_top_s;

    sdcd_top_s st_ff;
    sdcd_top_s nxt_st;
    sdcd_beat_if beat_if ();
    sdcd_cmd_e cmd;
    logic rst_any;

    // command from strobes
    function automatic sdcd_cmd_e decode(input logic cs_n, input logic ras_n,
                                         input logic cas_n, input logic we_n);
        sdcd_cmd_e c;
        c = CMD_ILL;
        case ({cs_n, ras_n, cas_n, we_n})
            4'h0: c = CMD_MRS;
            4'h1: c = CMD_REF;
            4'h2: c = CMD_PRE;
            4'h3: c = CMD_ACT;
            4'h4: c = CMD_WR;
            4'h5: c = CMD_RD;
            4'h6: c = CMD_ZQ;
            4'h7: c = CMD_NOP;
            default: c = CMD_DES;
        endcase
        return c;
    endfunction

    // beat index for burst position
    function automatic logic [2:0] beat_index(input logic rd, input logic seq,
                                              input logic [2:0] start,
                                              input logic [2:0] n);
        logic [2:0] r;
        r = 3'h0;
        if (!rd)
        begin
            r = start + n; // R11
        end
        else if (seq)
        begin
            r = {start[2] ^ n[2], 2'(start[1:0] + n[1:0])}; // R8
        end
        else
        begin
            r = start ^ n; // R9
        end
        return r;
    endfunction

    assign cmd = decode(i_cs_n, i_ras_n, i_cas_n, i_we_n); // R1
    // either reset input resets the whole block, buffer included; rd_ok and odt load high, the rest clears
    assign rst_any = i_reset || !i_reset_n;

    always_comb
    begin
        logic quiet;
        logic hh;
        logic [1:0] bl;
        logic [2:0] st;
        quiet = (cmd == CMD_NOP) || (cmd == CMD_DES);
        hh = st_ff.cke_prev && i_cke;
        bl = st_ff.mr0[MR0_BL_LSB +: 2];
        st = i_addr[2:0];
        nxt_st = st_ff;
        nxt_st.cke_prev = i_cke; // R14
        nxt_st.pulse = 1'b0;
        // burst sequencer, stalls on buffer back-pressure
        if (st_ff.bact && beat_if.ready)
        begin
            nxt_st.bcnt = st_ff.bcnt + 3'h1;
            if (st_ff.bcnt == 3'h3 && st_ff.brd && st_ff.bchop)
            begin
                nxt_st.oe = 1'b0; // R10
            end
            if (st_ff.bcnt == 3'h7)
            begin
                nxt_st.bact = 1'b0; // R12
                nxt_st.oe = 1'b0;
                if (st_ff.bap)
                begin
                    nxt_st.open[st_ff.bbank] = 1'b0;
                end
            end
        end
        case (st_ff.ps)
            PS_IDLE:
            begin
                if (hh && !quiet) // R13
                begin
                    nxt_st.cmd = cmd;
                    nxt_st.pulse = 1'b1;
                    nxt_st.bank = i_ba; // R4
                    nxt_st.addr = i_addr;
                    nxt_st.ap = i_addr[AP_BIT];
                    nxt_st.chop = 1'b0;
                end
                if (hh)
                begin
                    case (cmd)
                        CMD_MRS:
                        begin
                            case (i_ba[1:0]) // R3
                                2'h0: nxt_st.mr0 = i_addr;
                                2'h1: nxt_st.mr1 = i_addr;
                                2'h2: nxt_st.mr2 = i_addr;
                                default: nxt_st.mr3 = i_addr;
                            endcase
                        end
                        CMD_ACT: nxt_st.open[i_ba] = 1'b1; // R4
                        CMD_PRE:
                        begin
                            if (i_addr[AP_BIT])
                            begin
                                nxt_st.open = '0; // R4
                            end
                            else
                            begin
                                nxt_st.open[i_ba] = 1'b0;
                            end
                        end
                        CMD_RD, CMD_WR:
                        begin
                            if (!st_ff.bact) // R12
                            begin
                                nxt_st.bact = 1'b1;
                                nxt_st.brd = (cmd == CMD_RD); // R5
                                nxt_st.bseq = !st_ff.mr0[MR0_BT_BIT];
                                nxt_st.bchop = (bl == BL_FIX4) ||
                                               ((bl == BL_OTF) && !i_addr[BC_BIT]); // R6 R24
                                nxt_st.chop = nxt_st.bchop;
                                if (cmd == CMD_RD)
                                begin
                                    nxt_st.bstart = st; // R7
                                end
                                else
                                begin
                                    nxt_st.bstart = nxt_st.bchop ? {st[2], 2'h0} : 3'h0; // R11
                                end
                                nxt_st.bcnt = 3'h0;
                                nxt_st.bbank = i_ba;
                                nxt_st.bap = i_addr[AP_BIT]; // R5
                                nxt_st.oe = (cmd == CMD_RD);
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
                if (st_ff.cke_prev && !i_cke)
                begin
                    if (cmd == CMD_REF)
                    begin
                        nxt_st.ps = PS_SREF; // R18
                    end
                    else if (quiet)
                    begin
                        // R16 R17
                        nxt_st.ps = (st_ff.open == '0) ? PS_PPD : PS_APD;
                    end
                end
            end
            PS_APD, PS_PPD:
            begin
                if (!st_ff.cke_prev && i_cke && quiet)
                begin
                    nxt_st.ps = PS_IDLE; // R16
                end
                else
                begin
                    nxt_st.ps = (st_ff.open == '0) ? PS_PPD : PS_APD; // R17
                end
            end
            PS_SREF:
            begin
                // R21
                if (i_cke)
                begin
                    nxt_st.ps = PS_XSR;
                    nxt_st.xcnt = 8'h00;
                    nxt_st.rd_ok = 1'b0;
                end
            end
            PS_XSR:
            begin
                nxt_st.xcnt = st_ff.xcnt + 8'h01; // R25
                if (st_ff.xcnt >= XSDLL_CYC)
                begin
                    nxt_st.rd_ok = 1'b1; // R20
                    nxt_st.ps = PS_IDLE;
                end
            end
            default: nxt_st.ps = PS_IDLE;
        endcase
        nxt_st.odt = (nxt_st.ps != PS_SREF); // R21
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (rst_any) // R2
        begin
            st_ff <= '0;
            st_ff.rd_ok <= 1'b1;
            st_ff.odt <= 1'b1;
            st_ff.mr0 <= MR_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // beats into buffer, every slot pushed; floated slots carry the enable bit low
    assign beat_if.valid = st_ff.bact;
    assign beat_if.data = {st_ff.brd, st_ff.oe, 3'h0, st_ff.bbank, st_ff.bcnt, 2'h0,
                           beat_index(st_ff.brd, st_ff.bseq, st_ff.bstart, st_ff.bcnt)};

    sdcd_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo
    (
        .i_ref_clk (i_ref_clk),
        .i_reset   (rst_any),
        .s_in      (beat_if),
        .o_data    (o_beat),
        .o_valid   (o_beat_valid),
        .i_ready   (i_beat_ready)
    );

    assign o_cmd         = st_ff.cmd;
    assign o_cmd_pulse   = st_ff.pulse;
    assign o_cmd_bank    = st_ff.bank;
    assign o_cmd_addr    = st_ff.addr;
    assign o_auto_pre    = st_ff.ap;
    assign o_chop        = st_ff.chop;
    assign o_bank_open   = st_ff.open;
    assign o_pstate      = st_ff.ps;
    assign o_odt_allowed = st_ff.odt; // R21
    assign o_read_ok     = st_ff.rd_ok;
    assign o_busy        = st_ff.bact;
    assign o_dq_oe       = st_ff.oe;
    assign o_mr0         = st_ff.mr0;
endmodule

// [tb/sdcd_ctrl.sv]
// Purpose: controller model driving command and clock-enable pins
// Assumes: pins change at the falling clock edge
// Notes: a no operation slot may go out as deselect with scrambled strobes
module sdcd_ctrl
    import sdcd_pkg::*;
(
    input  wire logic        i_ref_clk,
    output logic             o_cke,
    output logic             o_cs_n,
    output logic [2:0]       o_rcw,
    output logic [2:0]       o_ba,
    output logic [ROW_W-1:0] o_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_cke = 1'b0;
        o_cs_n = 1'b1;
        o_rcw = 3'h7;
        o_ba = 3'h0;
        o_addr = 16'h0000;
    end
    // one command slot, then no operation until the enable hold count ends
    task automatic issue(input logic c, input logic [2:0] r, input logic [2:0] b,
                         input logic [15:0] a);
        int n;
        n = (c != o_cke) ? int'(CKE_MIN_CYC) : 1;
        @(negedge i_ref_clk);
        o_cke = c;
        o_cs_n = (r == 3'h7) ? 1'($urandom) : 1'b0;
        o_rcw = (o_cs_n) ? 3'($urandom) : r;
        o_ba = b;
        o_addr = a;
        @(negedge i_ref_clk);
        o_cs_n = 1'b0;
        o_rcw = 3'h7;
        o_addr = 16'($urandom);
        repeat (n - 1) @(negedge i_ref_clk);
    endtask
endmodule

// [tb/sdcd_props.sv]
// Purpose: concurrent checks on the decoder top ports
// Assumes: one clock domain, reset by either reset input
// Notes: attached by bind at the foot of this file
module sdcd_props
    import sdcd_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_reset,
    input wire logic              i_reset_n,
    input wire logic              i_cke,
    input wire logic              i_cs_n,
    input wire logic              i_ras_n,
    input wire logic              i_cas_n,
    input wire logic              i_we_n,
    input wire logic [2:0]        i_ba,
    input wire logic [ROW_W-1:0]  i_addr,
    input wire logic [3:0]        o_cmd,
    input wire logic              o_cmd_pulse,
    input wire logic [2:0]        o_cmd_bank,
    input wire logic [ROW_W-1:0]  o_cmd_addr,
    input wire logic              o_auto_pre,
    input wire logic [BANK_N-1:0] o_bank_open,
    input wire logic [2:0]        o_pstate,
    input wire logic              o_odt_allowed,
    input wire logic              o_read_ok,
    input wire logic [MR_W-1:0]   o_mr0
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset || !i_reset_n);
    logic nop_cmd;
    assign nop_cmd = i_cs_n || (i_ras_n && i_cas_n && i_we_n);
    // previous edge out of reset
    sequence s_run;
        !$past(i_reset) && $past(i_reset_n);
    endsequence
    sequence s_ready;
        s_run ##0 $past(i_cke) && i_cke && o_pstate == PS_IDLE;
    endsequence
    sequence s_cmd(logic [2:0] c);
        s_ready ##0 !i_cs_n && {i_ras_n, i_cas_n, i_we_n} == c;
    endsequence
    chk_cmd_pulse: assert property (s_ready ##0 !nop_cmd |-> ##1 o_cmd_pulse)
        else $error("command without pulse");
    chk_nop_quiet: assert property (nop_cmd |-> ##1 !o_cmd_pulse)
        else $error("pulse after no operation");
    chk_rd_fields: assert property (s_cmd(3'h5) |-> ##1 o_cmd == CMD_RD &&
        o_cmd_bank == $past(i_ba) && o_auto_pre == $past(i_addr[AP_BIT]))
        else $error("read fields wrong");
    chk_act_open: assert property (s_cmd(3'h3) |->
        ##1 o_cmd_bank == $past(i_ba) ##[0:1] o_bank_open[o_cmd_bank])
        else $error("activate left bank closed");
    chk_prea_close: assert property (s_cmd(3'h2) ##0 i_addr[AP_BIT] |->
        ##[1:2] o_bank_open == '0)
        else $error("precharge all left a bank open");
    chk_mr_load: assert property (s_cmd(3'h0) ##0 i_ba == 3'h0 |->
        ##1 o_cmd_addr == $past(i_addr) ##[0:1] o_mr0 == o_cmd_addr)
        else $error("mode register not loaded");
    chk_pd_entry: assert property (s_run ##0 $past(i_cke) && !i_cke && nop_cmd &&
        o_pstate == PS_IDLE && o_bank_open == '0 |-> ##[1:2] o_pstate == PS_PPD)
        else $error("no precharge power-down");
    chk_sr_odt: assert property (o_pstate == PS_SREF |-> !o_odt_allowed)
        else $error("termination allowed in self refresh");
    chk_sr_exit: assert property (o_pstate == PS_SREF && i_cke |->
        ##[1:2] o_pstate == PS_XSR && !o_read_ok)
        else $error("self refresh exit wrong");
endmodule

bind sdcd_top sdcd_props i_props (.*);

// [tb/testbench.sv]
// Purpose: self-checking bench of the command decoder top
// Assumes: controller model issues every command
// Notes: random starts, banks and chop bits from a fixed seed
module testbench
    import sdcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk, i_reset, i_reset_n, i_beat_ready;
    logic i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, o_cmd_pulse, o_auto_pre, o_chop;
    logic o_beat_valid, o_odt_allowed, o_read_ok, o_busy, o_dq_oe;
    logic [2:0] i_ba, o_cmd_bank, o_pstate;
    logic [3:0] o_cmd;
    logic [15:0] i_addr, o_beat, o_cmd_addr, o_mr0;
    logic [7:0] o_bank_open;
    int num_errors, check_count, cyc, m;
    logic [2:0] rcw;
    sdcd_ctrl i_ctrl (.i_ref_clk(i_ref_clk), .o_cke(i_cke), .o_cs_n(i_cs_n),
        .o_rcw(rcw), .o_ba(i_ba), .o_addr(i_addr));
    assign {i_ras_n, i_cas_n, i_we_n} = rcw;
    sdcd_top i_dut (.*);
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [2:0] idx(bit wr, bit ch, bit il, logic [2:0] s, logic [2:0] n);
        if (wr)
            return ch ? {s[2], n[1:0]} : n;
        if (il)
            return s ^ n;
        return {s[2] ^ n[2], s[1:0] + n[1:0]};
    endfunction
    task automatic burst(input bit wr, input logic [1:0] bl, input bit il, input logic [2:0] s);
        logic [2:0] b;
        logic [15:0] a;
        bit ch;
        int k, t;
        b = 3'($urandom);
        a = {3'h0, 1'($urandom), 1'b0, 1'($urandom), 7'h00, s};
        ch = (bl == BL_FIX4) || (bl == BL_OTF && !a[BC_BIT]);
        i_ctrl.issue(1'b1, 3'h3, b, 16'h0001);
        i_ctrl.issue(1'b1, wr ? 3'h4 : 3'h5, b, a);
        chk("cmd", wr ? CMD_WR : CMD_RD, o_cmd);
        chk("chop", ch, o_chop);
        chk("auto", a[AP_BIT], o_auto_pre);
        chk("oe", !wr, o_dq_oe);
        chk("busy", 16'h0001, o_busy);
        i_beat_ready = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        k = 0;
        for (t = 0; t < 80 && k < 8; t++)
        begin
            @(negedge i_ref_clk);
            i_beat_ready = ($urandom % 3) != 0;
            if (o_beat_valid && i_beat_ready)
            begin
                if (k < 4 || !ch)
                    chk("beat", {!wr, !wr, 3'h0, b, k[2:0], 2'h0, idx(wr, ch, il, s, k[2:0])},
                        o_beat & (wr ? 16'h87E7 : 16'hC7E7));
                else if (!wr)
                    chk("float", 16'h0000, {15'h0, o_beat[14]});
                k++;
            end
        end
        chk("beats", 16'h0008, k[15:0]);
        for (t = 0; t < 40 && o_busy !== 1'b0; t++)
            @(negedge i_ref_clk);
        repeat (3) @(negedge i_ref_clk);
        chk("open", !a[AP_BIT], o_bank_open[b]);
        i_ctrl.issue(1'b1, 3'h2, 3'h0, 16'h0400);
        chk("prea", 16'h0000, o_bank_open);
    endtask
    initial
    begin
        void'($urandom(97922));
        i_reset = 1'b1;
        i_reset_n = 1'b1;
        i_beat_ready = 1'b0;
        repeat (16) @(negedge i_ref_clk);
        i_reset = 1'b0;
        chk("rst", {2'h3, PS_IDLE, 11'h0}, {o_read_ok, o_odt_allowed, o_pstate, 11'h0});
        chk("mr0", MR_RESET, o_mr0);
        i_ctrl.issue(1'b1, 3'h7, 3'h0, 16'h0000);
        for (m = 0; m < 6; m++)
        begin
            i_ctrl.issue(1'b1, 3'h0, 3'h0, {12'h0, 1'(m / 3), 1'b0, 2'(m % 3)});
            chk("mr0", {12'h0, 1'(m / 3), 1'b0, 2'(m % 3)}, o_mr0);
            burst(1'b0, 2'(m % 3), 1'(m / 3), (m == 0) ? 3'h1 : 3'($urandom));
            burst(1'b1, 2'(m % 3), 1'(m / 3), 3'($urandom));
            $display("burst mode %0d done", m);
        end
        i_ctrl.issue(1'b1, 3'h0, 3'h1, 16'hFFFF);
        chk("mr1", {12'h0, 1'b1, 1'b0, BL_FIX4}, o_mr0);
        i_ctrl.issue(1'b1, 3'h6, 3'h0, 16'h0400);
        chk("zq", CMD_ZQ, o_cmd);
        i_ctrl.issue(1'b1, 3'h1, 3'h0, 16'h0000);
        i_ctrl.issue(1'b1, 3'h7, 3'h0, 16'h0000);
        chk("nop", CMD_REF, o_cmd);
        i_ctrl.issue(1'b0, 3'h7, 3'h0, 16'h0000);
        chk("ppd", PS_PPD, o_pstate);
        i_ctrl.issue(1'b1, 3'h7, 3'h0, 16'h0000);
        chk("pdx", PS_IDLE, o_pstate);
        i_ctrl.issue(1'b1, 3'h3, 3'h2, 16'h0000);
        i_ctrl.issue(1'b0, 3'h7, 3'h0, 16'h0000);
        chk("apd", PS_APD, o_pstate);
        i_ctrl.issue(1'b1, 3'h7, 3'h0, 16'h0000);
        i_ctrl.issue(1'b1, 3'h2, 3'h0, 16'h0400);
        i_ctrl.issue(1'b0, 3'h1, 3'h0, 16'h0000);
        chk("sref", {PS_SREF, 1'b0}, {o_pstate, o_odt_allowed});
        i_ctrl.issue(1'b1, 3'h7, 3'h0, 16'h0000);
        chk("xsr", {PS_XSR, 1'b0}, {o_pstate, o_read_ok});
        repeat (int'(XSDLL_CYC) + 2) @(negedge i_ref_clk);
        chk("xsdll", {PS_IDLE, 1'b1}, {o_pstate, o_read_ok});
        $display("power states done");
        i_reset_n = 1'b0;
        @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        chk("pinrst", MR_RESET, o_mr0);
        stop_test();
    end
endmodule
